// >>> logic/dsg_clock_gate.sv
`timescale 1ns/1ps
module dsg_clock_gate (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register bus
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Power state
    input wire dsg_pkg::dsg_power_t power_state_i,
    // Peripheral access monitor
    input wire logic [5:0] unit_access_i,
    output logic [5:0] unit_fault_o,
    // Gating outputs
    output logic [5:0] unit_clk_en_o,
    output logic [5:0] unit_clk_o,
    output logic [1:0] sampler_rate_o,
    output logic irq_o
);
    import dsg_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] run_q;
    logic [31:0] sleep_q;
    logic [31:0] deep_q;
    logic auto_q;
    logic [5:0] stat_q;
    logic [5:0] mask_q;
    logic [31:0] sel;
    logic [5:0] en_d;
    logic [5:0] fault_d;
    logic [5:0] en_q;
    logic [5:0] en_lat_q;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            run_q <= DSG_RUN_RST;
            sleep_q <= DSG_SLEEP_RST;
            deep_q <= DSG_DEEP_RST;
        end
        else if (wr_i)
        begin
            // Reserved bits never stored
            if (addr_i == DSG_RUN_GATE_OFS)
                run_q <= wdata_i & DSG_GATE_WMASK;
            if (addr_i == DSG_SLEEP_GATE_OFS)
                sleep_q <= wdata_i & DSG_GATE_WMASK;
            if (addr_i == DSG_DEEP_GATE_OFS)
                deep_q <= wdata_i & DSG_GATE_WMASK;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            auto_q <= 1'b0;
        else if (wr_i && addr_i == DSG_RUN_CFG_OFS)
            auto_q <= wdata_i[DSG_AUTO_GATE_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            mask_q <= DSG_STAT_RST;
        else if (wr_i && addr_i == DSG_FAULT_MASK_OFS)
            mask_q <= wdata_i[5:0];
    end

    // ----------------------------------------------------------------
    // Set selection by power state
    // ----------------------------------------------------------------
    always_comb
    begin
        sel = run_q;
        if (auto_q)
        begin
            unique case (power_state_i)
                DSG_RUN: sel = run_q;
                DSG_SLEEP: sel = sleep_q;
                DSG_DEEP: sel = deep_q;
                default: sel = run_q;
            endcase
        end
    end

    // One enable per unit, one fault term per faulting unit
    for (genvar u = 0; u < DSG_NUM_UNITS; u++)
    begin : g_unit
        assign en_d[u] = sel[DSG_UNIT_BIT[u]];
        assign fault_d[u] = DSG_FAULT_UNITS[u] && unit_access_i[u] && !en_q[u];
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            en_q <= DSG_STAT_RST;
        else
            en_q <= en_d;
    end

    // ----------------------------------------------------------------
    // Glitch-free gate: enable latched on the low phase
    // ----------------------------------------------------------------
    // Enable only moves while clk is low, so no runt pulse appears.
    always_ff @(negedge clk_i)
    begin
        if (!reset_n_i)
            en_lat_q <= DSG_STAT_RST;
        else
            en_lat_q <= en_q;
    end

    assign unit_clk_o = en_lat_q & {DSG_NUM_UNITS{clk_i}};

    // ----------------------------------------------------------------
    // Outputs, faults, interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            unit_clk_en_o <= DSG_STAT_RST;
            unit_fault_o <= DSG_STAT_RST;
            sampler_rate_o <= 2'h0;
        end
        else
        begin
            unit_clk_en_o <= en_d;
            unit_fault_o <= fault_d;
            // Only codes 0..3 are defined; upper bits ignored
            sampler_rate_o <= sel[DSG_RATE_LSB +: 2];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            stat_q <= DSG_STAT_RST;
        else if (wr_i && addr_i == DSG_FAULT_STAT_OFS)
            stat_q <= (stat_q & ~wdata_i[5:0]) | fault_d;
        else
            stat_q <= stat_q | fault_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((stat_q | fault_d) & mask_q);
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            rdata_o <= 32'h00000000;
        else if (rd_i)
        begin
            unique case (addr_i)
                DSG_RUN_GATE_OFS: rdata_o <= run_q;
                DSG_SLEEP_GATE_OFS: rdata_o <= sleep_q;
                DSG_DEEP_GATE_OFS: rdata_o <= deep_q;
                DSG_RUN_CFG_OFS: rdata_o <= {4'h0, auto_q, 27'h0000000};
                DSG_FAULT_STAT_OFS: rdata_o <= {26'h0000000, stat_q};
                DSG_FAULT_MASK_OFS: rdata_o <= {26'h0000000, mask_q};
                default: rdata_o <= 32'h00000000;
            endcase
        end
        else
            rdata_o <= 32'h00000000;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_deep_reset_val: assert property (@(posedge clk_i) $rose(reset_n_i) |-> deep_q == 32'h00000040)
        else $error("deep gate reset value wrong");
    a_run_reset_val: assert property (@(posedge clk_i) $rose(reset_n_i) |-> run_q == 32'h0)
        else $error("run gate not zero after reset");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd_i && addr_i == DSG_DEEP_GATE_OFS |=> rdata_o[31:26] == 6'h00)
        else $error("reserved bits read nonzero");
    a_wdt_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        unit_access_i[0] && !en_q[0] |=> unit_fault_o[0])
        else $error("watchdog access without fault");
    a_pwm_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        unit_access_i[3] && !en_q[3] |=> unit_fault_o[3])
        else $error("modulator access without fault");
    a_conv_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        unit_access_i[2] && !en_q[2] |=> unit_fault_o[2])
        else $error("converter access without fault");
    a_no_false_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_q[0] |=> !unit_fault_o[0])
        else $error("fault on clocked unit");
    a_hib_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q && run_q[6] |=> unit_clk_en_o[1])
        else $error("hibernation clock not enabled");
    a_run_governs: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q |=> unit_clk_en_o[5] == $past(run_q[25]) && unit_clk_en_o[4] == $past(run_q[24]))
        else $error("run set not governing");
    a_deep_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        auto_q && power_state_i == DSG_DEEP |=> unit_clk_en_o[1] == $past(deep_q[6]))
        else $error("deep set not selected");
    a_rate_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q |=> sampler_rate_o == $past(run_q[9:8]))
        else $error("sampler rate wrong");

    // ----------------------------------------------------------------
    // Selection checks
    // ----------------------------------------------------------------
    a_sleep_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        auto_q && power_state_i == DSG_SLEEP |=> unit_clk_en_o[1] == $past(sleep_q[6]))
        else $error("sleep set not selected");
    a_run_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        auto_q && power_state_i == DSG_RUN |=> unit_clk_en_o[0] == $past(run_q[3]))
        else $error("run set not selected");
    a_deep_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        auto_q && power_state_i == DSG_DEEP |=> sampler_rate_o == $past(deep_q[9:8]))
        else $error("deep rate not selected");
    a_sleep_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        auto_q && power_state_i == DSG_SLEEP |=> sampler_rate_o == $past(sleep_q[9:8]))
        else $error("sleep rate not selected");
    a_wdt_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q |=> unit_clk_en_o[0] == $past(run_q[3]))
        else $error("watchdog enable wrong");
    a_hib_disable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q && !run_q[6] |=> !unit_clk_en_o[1])
        else $error("hibernation clock not stopped");
    a_conv_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q |=> unit_clk_en_o[2] == $past(run_q[16]))
        else $error("converter enable wrong");
    a_pwm_enable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q |=> unit_clk_en_o[3] == $past(run_q[20]))
        else $error("modulator enable wrong");
    a_first_bus_controller_clock_enable_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q && !run_q[24] |=> !unit_clk_en_o[4])
        else $error("first bus controller not stopped");
    a_second_bus_controller_clock_enable_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !auto_q && !run_q[25] |=> !unit_clk_en_o[5])
        else $error("second bus controller not stopped");

    // ----------------------------------------------------------------
    // Fault and interrupt checks
    // ----------------------------------------------------------------
    a_hib_no_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        unit_access_i[1] |=> !unit_fault_o[1])
        else $error("hibernation access faulted");
    a_can_no_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        |unit_access_i[5:4] |=> unit_fault_o[5:4] == 2'h0)
        else $error("bus controller access faulted");
    a_conv_no_false: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_q[2] |=> !unit_fault_o[2])
        else $error("fault on clocked converter");
    a_pwm_no_false: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_q[3] |=> !unit_fault_o[3])
        else $error("fault on clocked modulator");
    a_fault_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        |unit_fault_o |-> (stat_q & unit_fault_o) == unit_fault_o)
        else $error("fault not latched in status");
    a_irq_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (stat_q & mask_q) != 6'h00 |=> irq_o)
        else $error("interrupt low with unmasked status");
    a_irq_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mask_q == 6'h00 |=> !irq_o)
        else $error("interrupt high while masked");

    // ----------------------------------------------------------------
    // Storage, reset and gate checks
    // ----------------------------------------------------------------
    a_run_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (run_q & ~DSG_GATE_WMASK) == 32'h00000000)
        else $error("run set reserved bit stored");
    a_sleep_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sleep_q & ~DSG_GATE_WMASK) == 32'h00000000)
        else $error("sleep set reserved bit stored");
    a_deep_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (deep_q & ~DSG_GATE_WMASK) == 32'h00000000)
        else $error("deep set reserved bit stored");
    a_rdata_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !rd_i |=> rdata_o == 32'h00000000)
        else $error("read data without strobe");
    a_sleep_reset_val: assert property (@(posedge clk_i) $rose(reset_n_i) |-> sleep_q == 32'h0)
        else $error("sleep gate not zero after reset");
    a_auto_reset_val: assert property (@(posedge clk_i) $rose(reset_n_i) |-> !auto_q)
        else $error("auto gating set after reset");
    a_enable_reset: assert property (@(posedge clk_i) $rose(reset_n_i) |-> unit_clk_en_o == 6'h00)
        else $error("unit enabled after reset");
    a_fault_reset: assert property (@(posedge clk_i) $rose(reset_n_i) |-> unit_fault_o == 6'h00)
        else $error("fault raised after reset");
    // Latched enable must match the registered one at every rising edge
    a_latch_match: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_lat_q == en_q)
        else $error("latched enable out of step");
    a_enable_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> en_q == $past(en_d))
        else $error("enable did not follow selection");
endmodule // dsg_clock_gate

// >>> logic/dsg_pkg.sv
//
// Contract
// - Rate field bits 11:8 picks sampler rate: 3=1M, 2=500K, 1=250K, 0=125K.
// - Bit 6 set clocks the hibernation unit; clear leaves it stopped.
// - Bit 3 gates watchdog clock; access while unclocked gives a bus fault.
// - Bit 25 enables second bus controller clock; clear disables it.
// - Bit 24 enables first bus controller clock; clear disables it.
// - Bit 20 gates modulator clock; access while clear gives a bus fault.
// - Bit 16 gates converter zero clock; access while clear faults.
// - Each gating bit is one unit's clock enable: one runs, zero stops.
// - Access to any unit whose clock is gated off answers with bus fault; here only wdt, conv0 and pwm fault.
// - Gating bits reset to zero unless another reset value is given.
// - Deep-sleep register at 0x120, resets to 0x00000040.
// - Three gating sets: run, sleep, deep sleep; pick by power state.
// - Sleep sets apply only with auto gating set; otherwise run set rules.
// - Reserved bits read zero, ignore writes; software preserves them.
//
package dsg_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] DSG_RUN_GATE_OFS = 12'h100;
    localparam logic [11:0] DSG_SLEEP_GATE_OFS = 12'h110;
    localparam logic [11:0] DSG_DEEP_GATE_OFS = 12'h120;
    localparam logic [11:0] DSG_RUN_CFG_OFS = 12'h060;
    localparam logic [11:0] DSG_FAULT_STAT_OFS = 12'h140;
    localparam logic [11:0] DSG_FAULT_MASK_OFS = 12'h144;
    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] DSG_GATE_WMASK = 32'h03110F48;
    localparam logic [31:0] DSG_RUN_RST = 32'h00000000;
    localparam logic [31:0] DSG_SLEEP_RST = 32'h00000000;
    localparam logic [31:0] DSG_DEEP_RST = 32'h00000040;
    localparam int DSG_AUTO_GATE_BIT = 27;
    localparam int DSG_RATE_LSB = 8;
    localparam int DSG_NUM_UNITS = 6;
    // Unit order: wdt, hib, conv0, pwm, bus ctl 0, bus ctl 1
    localparam int DSG_UNIT_BIT [DSG_NUM_UNITS] = '{3, 6, 16, 20, 24, 25};
    localparam logic [5:0] DSG_FAULT_UNITS = 6'h0D;
    localparam logic [5:0] DSG_STAT_RST = 6'h00;
    // Power states
    typedef enum logic [1:0] {DSG_RUN, DSG_SLEEP, DSG_DEEP} dsg_power_t;
endpackage

// >>> testbench/deep_sleep_clock_gating_tb_top.sv
`timescale 1ns/1ps
module deep_sleep_clock_gating_tb_top;
    import dsg_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    dsg_power_t power_state_i = DSG_DEEP;
    logic [5:0] unit_access_i = 6'h00;
    logic [31:0] rdata_o;
    logic [5:0] unit_fault_o;
    logic [5:0] unit_clk_en_o;
    logic [5:0] unit_clk_o;
    logic [1:0] sampler_rate_o;
    logic irq_o;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h69E0D3B1;
    logic [31:0] rr, rs, rd_set, t, sel;

    always #25 clk_i = ~clk_i;

    dsg_clock_gate u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .power_state_i(power_state_i), .unit_access_i(unit_access_i),
        .unit_fault_o(unit_fault_o), .unit_clk_en_o(unit_clk_en_o),
        .unit_clk_o(unit_clk_o), .sampler_rate_o(sampler_rate_o), .irq_o(irq_o));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Run takes about 270 cycles; generous ceiling
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic [5:0] en_of(input logic [31:0] r);
        for (int i = 0; i < DSG_NUM_UNITS; i++)
            en_of[i] = r[DSG_UNIT_BIT[i]];
    endfunction

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(n, rdata_o, e);
    endtask

    task access(input logic [5:0] a, input logic [5:0] e);
        @(posedge clk_i);
        unit_access_i <= a;
        @(posedge clk_i);
        unit_access_i <= 6'h00;
        #1 chk("unit_fault_o", {26'h0, unit_fault_o}, {26'h0, e});
    endtask

    // Gated clock follows clk_i in the high phase, low otherwise
    task clk_chk(input logic [5:0] e);
        @(posedge clk_i);
        #10 chk("unit_clk_o high", {26'h0, unit_clk_o}, {26'h0, e});
        @(negedge clk_i);
        #10 chk("unit_clk_o low", {26'h0, unit_clk_o}, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd_chk("deep set", DSG_DEEP_GATE_OFS, 32'h00000040);
        rd_chk("run set", DSG_RUN_GATE_OFS, 32'h0);
        rd_chk("sleep set", DSG_SLEEP_GATE_OFS, 32'h0);
        rd_chk("unmapped", 12'h1F0, 32'h0);
        chk("unit_clk_en_o", {26'h0, unit_clk_en_o}, 32'h0);
        clk_chk(6'h00);
        wr(DSG_DEEP_GATE_OFS, 32'hFFFFFFFF);
        rd_chk("deep set", DSG_DEEP_GATE_OFS, DSG_GATE_WMASK);
        wr(DSG_FAULT_MASK_OFS, 32'h3F);
        access(6'h3F, DSG_FAULT_UNITS);
        repeat (2) @(posedge clk_i);
        #1 chk("irq_o", {31'h0, irq_o}, 32'h1);
        rd_chk("fault status", DSG_FAULT_STAT_OFS, {26'h0, DSG_FAULT_UNITS});
        wr(DSG_FAULT_STAT_OFS, 32'h3F);
        repeat (2) @(posedge clk_i);
        #1 chk("irq_o", {31'h0, irq_o}, 32'h0);
        // Masked fault latches status but keeps the line quiet
        wr(DSG_FAULT_MASK_OFS, 32'h0);
        access(6'h08, 6'h08);
        repeat (2) @(posedge clk_i);
        #1 chk("irq_o", {31'h0, irq_o}, 32'h0);
        rd_chk("fault status", DSG_FAULT_STAT_OFS, 32'h08);
        for (int k = 0; k < 16; k++)
        begin
            rr = xs();
            rs = xs();
            rd_set = xs();
            t = xs();
            // Rate codes kept within the four defined values
            rr[11:10] = 2'h0;
            rs[11:10] = 2'h0;
            rd_set[11:10] = 2'h0;
            wr(DSG_RUN_GATE_OFS, rr);
            wr(DSG_SLEEP_GATE_OFS, rs);
            wr(DSG_DEEP_GATE_OFS, rd_set);
            wr(DSG_RUN_CFG_OFS, {4'h0, t[0], 27'h0});
            power_state_i <= dsg_power_t'(t[2:1]);
            repeat (3) @(posedge clk_i);
            sel = (t[0] && t[2:1] == 2'h1) ? rs : (t[0] && t[2:1] == 2'h2) ? rd_set : rr;
            #1 chk("unit_clk_en_o", {26'h0, unit_clk_en_o}, {26'h0, en_of(sel)});
            chk("sampler_rate_o", {30'h0, sampler_rate_o}, {30'h0, sel[9:8]});
            clk_chk(en_of(sel));
            access(t[8:3], t[8:3] & ~en_of(sel) & DSG_FAULT_UNITS);
        end
        test_done();
    end
endmodule // deep_sleep_clock_gating_tb_top
